//--- rtl/ee_pkg.sv
// Package for the data array program/erase control block.
// Assumes a 32-bit AXI4-Lite register bus and a single 25 MHz clock.
package ee_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] ctrl_off      = 12'h00c;
  localparam logic [11:0] opt_off       = 12'h010;
  localparam logic [11:0] sys_off       = 12'h014;
  localparam logic [11:0] array_base    = 12'h200;
  localparam logic [7:0]  ctrl_reset    = 8'h00;
  localparam logic [7:0]  ctrl_wmask    = 8'h1f;

  // ---------------------------------------------------------------
  // Control, option and status field positions
  // ---------------------------------------------------------------
  localparam int pos_power  = 0;
  localparam int pos_latch  = 1;
  localparam int pos_erlo   = 2;
  localparam int pos_erhi   = 3;
  localparam int pos_rcsel  = 4;
  localparam int pos_protect = 1;
  localparam int pos_stop   = 0;

  // ---------------------------------------------------------------
  // Array geometry and values
  // ---------------------------------------------------------------
  localparam int          array_bytes = 128;
  localparam int          addr_w      = 7;
  localparam logic [7:0]  erased_byte = 8'hff;
  localparam logic [7:0]  opt_default = 8'hff;

  // ---------------------------------------------------------------
  // Timing: oscillator settle time, ns, and clock period
  // ---------------------------------------------------------------
  localparam int clk_period_ns  = 40;
  localparam int rc_settle_ns   = 1000;
  localparam int rc_settle_cyc  =
    (rc_settle_ns + clk_period_ns - 1) / clk_period_ns;

  typedef enum logic [1:0] {
    er_none, er_byte, er_block, er_bulk
  } erase_e;

  typedef struct packed {
    logic        rc_clock_select;
    erase_e      erase_sel;
    logic        programming_latch;
    logic        programming_power;
  } ctrl_s;

  typedef struct packed {
    logic [addr_w-1:0] addr;
    logic [7:0]        data;
  } pend_s;

endpackage

//--- rtl/ee_cell_array.sv
// Nonvolatile byte array model: erase sets ones, program clears bits.
// Assumes one operation strobe per clock from the controller.
`timescale 1ns/1ps
module ee_cell_array
  import ee_pkg::*;
(
  // Clock
  input  wire logic              mclk,
  // Read port
  input  wire logic [addr_w-1:0] rd_addr,
  output logic [7:0]             rd_data,
  // Operation port
  input  wire logic              op_en,
  input  wire erase_e            op_mode,
  input  wire logic [addr_w-1:0] op_addr,
  input  wire logic [7:0]        op_data
);

  // Cells keep contents across reset, as nonvolatile storage does.
  logic [7:0] cells [array_bytes];

  assign rd_data = cells[rd_addr];

  // ---------------------------------------------------------------
  // Program and erase
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    for (int i = 0; i < array_bytes; i++) begin
      if (op_en) begin
        unique case (op_mode)
          er_none: begin
            if (addr_w'(i) == op_addr) begin
              cells[i] <= cells[i] & op_data;
            end
          end
          er_byte: begin
            if (addr_w'(i) == op_addr) begin
              cells[i] <= erased_byte;
            end
          end
          er_block: begin
            if (addr_w'(i) >> 6 == op_addr >> 6) begin
              cells[i] <= erased_byte;
            end
          end
          er_bulk: begin
            cells[i] <= erased_byte;
          end
        endcase
      end
    end
  end

endmodule

//--- rtl/ee_ctrl.sv
// Program/erase control for a 128-byte data array behind AXI4-Lite.
// Assumes a single-beat master, one write and one read in flight.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Contract
// - 128-byte array, read like ROM, programmed a byte at a time.
// - Erased bytes read all ones; programmed bits read zero.
// - Clock-select bit picks RC oscillator; read/write; reset clears.
// - Erase field: 00 none, 01 byte, 10 block, 11 bulk.
// - Block erase clears the 64-byte half holding the address.
// - Bulk erase clears all bytes; byte erase only one byte. Code skips bulk erase when address bits 1:0 are 00 or protect is zero.
// - Latch zero forces erase field and power bit to zero.
// - Latch set: array write latches address/data while power is zero.
// - STOP and every reset clear the latch bit.
// - Power bit drives pump; writable only with latch; clears otherwise.
// - Options copied into working latches at reset; storage kept.
// - Protect zero blocks program/erase of the upper block.
// - Protect change waits for reset; zero written only with latch.
// - Reads with latch set return all ones.
// - During programming every array access returns all ones.
// - Next byte needs latch cleared and set again first.
// - STOP switches off the array RC oscillator.
module ee_ctrl
  import ee_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Chip mode
  input  wire logic        stop_req,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Array power and clock controls
  output logic             pump_on,
  output logic             rc_osc_on,
  output logic             rc_clock_used
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ctrl_s             ctrl;
  pend_s             pend;
  logic              pend_valid;
  logic              armed;
  // A fresh part starts with every option bit erased.
  logic [7:0]        opt_store = opt_default;
  logic [7:0]        opt_work;
  logic              opt_loaded;
  logic              stop_s1;
  logic              stop_s2;
  logic              aw_held;
  logic              w_held;
  logic [11:0]       aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic [7:0]        cell_rd;
  logic [addr_w-1:0] rd_idx;
  logic              op_en;
  logic              wr_go;
  logic              in_array_w;
  logic              in_array_r;
  logic              upper_locked;
  logic [7:0]        next_ctrl_byte;

  // Decodes an address into the array window.
  function automatic logic is_array(input logic [11:0] a);
    return a[11:7] == array_base[11:7];
  endfunction

  assign in_array_w = is_array(aw_addr);
  assign in_array_r = is_array(s_axi_araddr);
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  // ---------------------------------------------------------------
  // Write channel capture, either order
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (in_array_w || aw_addr == ctrl_off ||
                       aw_addr == opt_off || aw_addr == sys_off)
                      ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // STOP request synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stop_s1 <= 1'b0;
      stop_s2 <= 1'b0;
    end else begin
      stop_s1 <= stop_req;
      stop_s2 <= stop_s1;
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_comb begin
    next_ctrl_byte = {3'b000, ctrl};
    if (wr_go && aw_addr == ctrl_off && w_strb[0]) begin
      next_ctrl_byte = w_data[7:0] & ctrl_wmask;
      // The power bit may only change while the latch is already set.
      if (!ctrl.programming_latch) begin
        next_ctrl_byte[pos_power] = 1'b0;
      end
    end
    if (stop_s2) begin
      next_ctrl_byte[pos_latch] = 1'b0;
    end
    if (!next_ctrl_byte[pos_latch]) begin
      next_ctrl_byte[pos_erhi:pos_erlo] = 2'b00;
      next_ctrl_byte[pos_power] = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= ctrl_s'(ctrl_reset[4:0]);
    end else begin
      ctrl <= ctrl_s'(next_ctrl_byte[4:0]);
    end
  end

  // ---------------------------------------------------------------
  // Latched address and data
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pend       <= '0;
      pend_valid <= 1'b0;
      armed      <= 1'b0;
    end else if (!ctrl.programming_latch) begin
      pend_valid <= 1'b0;
      armed      <= 1'b1;
    end else if (wr_go && in_array_w && w_strb[0] &&
                 !ctrl.programming_power && armed) begin
      pend.addr  <= aw_addr[addr_w-1:0];
      pend.data  <= w_data[7:0];
      pend_valid <= 1'b1;
    end else if (op_en) begin
      // One operation per latch cycle; relatch needs a fresh latch.
      pend_valid <= 1'b0;
      armed      <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Options: stored byte and working copy
  // ---------------------------------------------------------------
  // Storage survives reset; only the working copy reloads.
  always_ff @(posedge mclk) begin
    if (wr_go && aw_addr == opt_off && w_strb[0]) begin
      // Protect may rise at any time but falls only with the latch set.
      opt_store <= {w_data[7:2],
                    w_data[pos_protect] |
                      (!ctrl.programming_latch & opt_store[pos_protect]),
                    w_data[0]};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      opt_loaded <= 1'b0;
      opt_work   <= 8'h00;
    end else if (!opt_loaded) begin
      opt_loaded <= 1'b1;
      opt_work   <= opt_store;
    end
  end

  assign upper_locked = !opt_work[pos_protect];

  // ---------------------------------------------------------------
  // Array operation: power held exactly while the bit is set
  // ---------------------------------------------------------------
  assign pump_on = ctrl.programming_power;
  assign op_en = ctrl.programming_power && pend_valid &&
                 !(upper_locked && pend.addr[addr_w-1] &&
                   ctrl.erase_sel != er_bulk) &&
                 (ctrl.erase_sel != er_bulk ||
                  (pend.addr[1:0] != 2'b00 && !upper_locked));

  ee_cell_array u_cells (
    .mclk    (mclk),
    .rd_addr (rd_idx),
    .rd_data (cell_rd),
    .op_en   (op_en),
    .op_mode (ctrl.erase_sel),
    .op_addr (pend.addr),
    .op_data (pend.data)
  );

  assign rc_clock_used = ctrl.rc_clock_select;
  assign rc_osc_on = ctrl.rc_clock_select && !stop_s2;

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx = s_axi_araddr[addr_w-1:0];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      if (in_array_r) begin
        // Latch set or pump on hides contents.
        s_axi_rdata <= {24'h0, ctrl.programming_latch ? erased_byte
                                : cell_rd};
      end else if (s_axi_araddr == ctrl_off) begin
        s_axi_rdata <= {24'h0, 8'(ctrl)};
      end else if (s_axi_araddr == opt_off) begin
        s_axi_rdata <= {24'h0, opt_store};
      end else if (s_axi_araddr == sys_off) begin
        s_axi_rdata <= {30'h0, upper_locked, stop_s2};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_latch_gates_power: assert property (
    @(posedge mclk) disable iff (!nrst)
    !ctrl.programming_latch |-> !ctrl.programming_power &&
      ctrl.erase_sel == er_none)
    else $error("power or erase set without latch");

  a_stop_clears_latch: assert property (
    @(posedge mclk) disable iff (!nrst)
    stop_s2 |=> !ctrl.programming_latch)
    else $error("latch survived stop");

  a_pump_follows_bit: assert property (
    @(posedge mclk) disable iff (!nrst)
    pump_on == ctrl.programming_power)
    else $error("pump differs from power bit");

  a_read_hidden: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_axi_arvalid && !s_axi_rvalid && in_array_r &&
      ctrl.programming_latch |=> s_axi_rdata[7:0] == erased_byte)
    else $error("array read with latch not all ones");

  a_upper_protect: assert property (
    @(posedge mclk) disable iff (!nrst)
    op_en |-> !(upper_locked && pend.addr[addr_w-1]))
    else $error("protected block operated on");

  a_one_op_per_latch: assert property (
    @(posedge mclk) disable iff (!nrst)
    op_en |=> !pend_valid && !armed)
    else $error("second op without relatch");

  a_power_needs_latch: assert property (
    @(posedge mclk) disable iff (!nrst)
    $rose(ctrl.programming_power) |-> $past(ctrl.programming_latch))
    else $error("power set without prior latch");

  a_rc_off_in_stop: assert property (
    @(posedge mclk) disable iff (!nrst)
    stop_s2 |-> !rc_osc_on)
    else $error("rc oscillator on in stop");

  a_protect_held: assert property (
    @(posedge mclk) disable iff (!nrst)
    opt_loaded |=> $stable(opt_work))
    else $error("protect state changed without reset");

  a_latch_when_idle: assert property (
    @(posedge mclk) disable iff (!nrst)
    $rose(pend_valid) |-> $past(ctrl.programming_latch &&
      !ctrl.programming_power))
    else $error("address latched with power on");

  a_bulk_low_bits: assert property (
    @(posedge mclk) disable iff (!nrst)
    op_en && ctrl.erase_sel == er_bulk |-> pend.addr[1:0] != 2'b00)
    else $error("bulk erase without low address bit");

endmodule

//--- bench/data_eeprom_program_erase_control_bench.sv
// Self-checking bench for the data array program/erase control block.
// Assumes ee_pkg and ee_ctrl are compiled first; drives AXI4-Lite itself.
`timescale 1ns/1ps
module data_eeprom_program_erase_control_bench;
  import ee_pkg::*;

  typedef struct {
    string       name;
    logic [33:0] exp;
  } note_s;

  logic        mclk, nrst, stop_req;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [31:0] ra, rb;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        pump_on, rc_osc_on, rc_clock_used, locked;
  logic [7:0]  mem [128];
  int          failures, checks, cycles;
  note_s       notes[$];
  note_s       nt;

  ee_ctrl DUT (
    .mclk(mclk), .nrst(nrst), .stop_req(stop_req),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .pump_on(pump_on), .rc_osc_on(rc_osc_on),
    .rc_clock_used(rc_clock_used)
  );

  always #20 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [33:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run for ever.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [33:0] okb(input logic [7:0] b);
    return {26'h0, b};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    bready <= 1'b0;
    if (n >= 100) failures++;
    check("bresp", {32'h0, bresp}, 34'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e,
                    input string what);
    int n;
    n = 0;
    notes.push_back('{what, e});
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    if (n >= 100) failures++;
  endtask

  // Read results are matched against the oldest outstanding note.
  always @(posedge mclk) begin
    if (nrst && rvalid && rready) begin
      if (notes.size() == 0) begin
        check("stray_read", 34'h1, 34'h0);
      end else begin
        nt = notes.pop_front();
        check(nt.name, {rresp, rdata}, nt.exp);
      end
    end
  end

  task automatic reset_dut();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // One latched operation, mode m, with the bench model updated
  // ----------------------------------------------------------------
  task automatic op(input logic [1:0] m, input logic [6:0] i,
                    input logic [7:0] d);
    logic [7:0] c;
    c = {4'h0, m, 2'b10};
    wr(ctrl_off, {24'h0, c});
    rd(ctrl_off, okb(c), "ctrl_mode");
    wr(array_base + 12'(i), {24'h0, d});
    wr(ctrl_off, {24'h0, c | 8'h01});
    check("pump_on", {33'h0, pump_on}, 34'h1);
    rd(array_base + 12'(i), okb(erased_byte), "busy_read");
    wr(ctrl_off, 32'h0);
    check("pump_off", {33'h0, pump_on}, 34'h0);
    if (!(locked && (i[6] || m == 2'b11))) begin
      case (m)
        2'b00: mem[i] = mem[i] & d;
        2'b01: mem[i] = erased_byte;
        2'b10: for (int k = 0; k < 64; k++) mem[{i[6], 6'(k)}] = 8'hff;
        default: if (i[1:0] != 2'b00) mem = '{default: 8'hff};
      endcase
    end
  endtask

  task automatic sweep();
    for (int k = 0; k < array_bytes; k++)
      rd(array_base + 12'(k), okb(mem[k]), "array");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 0; nrst = 0; stop_req = 0; cycles = 0; seed = 7;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'h1;
    failures = 0; checks = 0; locked = 0;
    reset_dut();
    rd(ctrl_off, okb(ctrl_reset), "ctrl_reset");
    rd(opt_off, okb(opt_default), "opt_reset");
    rd(12'h040, {2'b10, 32'h0}, "unmapped");
    // Latch left clear, so erase and power bits must read back zero.
    wr(ctrl_off, 32'h1d);
    repeat (rc_settle_cyc) @(posedge mclk);
    rd(ctrl_off, okb(8'h10), "ctrl_unlatched");
    check("pump_idle", {33'h0, pump_on}, 34'h0);
    check("rc_used", {33'h0, rc_clock_used}, 34'h1);
    check("rc_osc", {33'h0, rc_osc_on}, 34'h1);
    wr(ctrl_off, 32'h0);
    wr(opt_off, 32'hfd);
    rd(opt_off, okb(8'hff), "opt_no_latch");
    op(2'b11, 7'h01, 8'h00);
    sweep();
    for (int k = 0; k < 6; k++) begin
      ra = xs();
      rb = xs();
      op(2'b00, ra[6:0], rb[7:0]);
    end
    op(2'b00, 7'h45, 8'h0f);
    op(2'b01, 7'h45, 8'h00);
    op(2'b10, 7'h10, 8'h00);
    sweep();
    // Second write under one latch set must not program.
    wr(ctrl_off, 32'h02);
    wr(array_base + 12'h005, 32'h0);
    wr(ctrl_off, 32'h03);
    wr(ctrl_off, 32'h02);
    wr(array_base + 12'h006, 32'h0);
    wr(ctrl_off, 32'h03);
    wr(ctrl_off, 32'h00);
    mem[5] = 8'h00;
    rd(array_base + 12'h005, okb(mem[5]), "first_prog");
    rd(array_base + 12'h006, okb(mem[6]), "second_prog");
    // Array write while power is on must not latch.
    wr(ctrl_off, 32'h02);
    wr(ctrl_off, 32'h03);
    wr(array_base + 12'h008, 32'h0);
    wr(ctrl_off, 32'h00);
    rd(array_base + 12'h008, okb(mem[8]), "power_latch");
    wr(ctrl_off, 32'h02);
    wr(opt_off, 32'hfd);
    wr(ctrl_off, 32'h00);
    rd(opt_off, okb(8'hfd), "opt_latched");
    rd(sys_off, okb(8'h00), "still_open");
    op(2'b00, 7'h70, 8'h5a);
    reset_dut();
    locked = 1;
    rd(ctrl_off, okb(8'h00), "ctrl_after_rst");
    rd(opt_off, okb(8'hfd), "opt_kept");
    rd(sys_off, okb(8'h02), "upper_locked");
    op(2'b00, 7'h71, 8'h00);
    op(2'b10, 7'h50, 8'h00);
    op(2'b11, 7'h02, 8'h00);
    op(2'b00, 7'h02, 8'h3c);
    sweep();
    wr(ctrl_off, 32'h12);
    stop_req <= 1'b1;
    repeat (4) @(posedge mclk);
    check("rc_stop", {33'h0, rc_osc_on}, 34'h0);
    stop_req <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(ctrl_off, okb(8'h10), "stop_latch");
    repeat (4) @(posedge mclk);
    end_of_test();
  end
endmodule
